/* design/fpe_pkg.sv */
// Package: constants, offsets, reset values and state types of the flash control block
package fpe_pkg;
   // Register indices (CPU byte addresses, one Avalon word each)
   localparam logic [15:0] FLASH_MODE_CTRL_IDX = 16'hFF80;
   localparam logic [15:0] LARGE_BLOCK_SEL_IDX = 16'hFF82;
   localparam logic [15:0] SMALL_BLOCK_SEL_IDX = 16'hFF83;
   localparam logic [15:0] WAIT_STATE_CTRL_IDX = 16'hFFC2;
   // Flash array window
   localparam logic [15:0] FLASH_LO            = 16'h0000;
   localparam logic [15:0] FLASH_HI            = 16'h7FFF;
   localparam int          FLASH_BYTES         = 32768;
   // Reset and forced values
   localparam logic [7:0]  MODE_CTRL_RST       = 8'h00;
   localparam logic [7:0]  LARGE_SEL_RST       = 8'hF0;
   localparam logic [7:0]  SMALL_SEL_RST       = 8'h00;
   localparam logic [7:0]  WAIT_CTRL_RST       = 8'h08;
   localparam logic [7:0]  OFF_READ            = 8'hFF;
   localparam logic [3:0]  LARGE_FIXED_ONES    = 4'hF;
   // Field positions in the mode control register
   localparam int          SUPPLY_BIT          = 7;
   localparam int          EV_BIT              = 3;
   localparam int          PV_BIT              = 2;
   localparam int          E_BIT               = 1;
   localparam int          P_BIT               = 0;
   // Mode pin codes {mode_pin_high, mode_pin_low}
   localparam logic [1:0]  MODE_ILLEGAL        = 2'h0;
   localparam logic [1:0]  MODE_EXTERNAL       = 2'h1;
   localparam logic [1:0]  MODE_ONCHIP_A       = 2'h2;
   localparam logic [1:0]  MODE_ONCHIP_B       = 2'h3;
   // Block boundaries of the small-block and large-block areas
   localparam logic [15:0] SMALL_AREA_END      = 16'h1000;
   localparam logic [15:0] SB4_START           = 16'h0200;
   localparam logic [15:0] SB5_START           = 16'h0400;
   localparam logic [15:0] SB6_START           = 16'h0800;
   localparam logic [15:0] SB7_START           = 16'h0C00;
   localparam logic [15:0] LB1_START           = 16'h2000;
   localparam logic [15:0] LB2_START           = 16'h4000;
   localparam logic [15:0] LB3_START           = 16'h6000;
   // Boot-mode bit rate measurement
   localparam int          CLOCK_HZ            = 250000000;
   localparam int          HOST_MAX_BPS        = 9600;
   localparam int          MIN_BIT_CYCLES      = CLOCK_HZ / HOST_MAX_BPS;
   localparam int          LOW_BITS            = 9;
   localparam int          RECIP_MUL           = 57;
   localparam int          RECIP_SHIFT         = 9;
   // Bus and sweep engine states
   typedef enum logic [1:0] {
      FPE_IDLE  = 2'b00,
      FPE_ACK   = 2'b01,
      FPE_ERASE = 2'b10
   } fpe_state_e;
   // Bit rate detector states
   typedef enum logic [1:0] {
      FPE_B_WAIT_HIGH = 2'b00,
      FPE_B_WAIT_LOW  = 2'b01,
      FPE_B_MEASURE   = 2'b10,
      FPE_B_LOCKED    = 2'b11
   } fpe_baud_e;
endpackage : fpe_pkg

/* design/fpe_sync.sv */
// Three-flop pin synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ns
module fpe_sync #(
   parameter int         WIDTH = 1,
   parameter logic [0:0] INIT  = 1'b0
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out
);
   // Stage flops and the filtered level
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } fpe_sync_s;

   fpe_sync_s st_reg;  // Registered state
   fpe_sync_s st_next; // Next state

   // Shift chain; the first stage feeds only the second
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < WIDTH; i++) begin
         // Accept a change once two later stages agree
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.lvl[i] = st_reg.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_reg <= {4 * WIDTH{INIT}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_out = st_reg.lvl;
endmodule : fpe_sync

/* design/fpe_baud.sv */
// Boot-mode host bit rate detector and matching bit tick generator
`timescale 1ns/1ns
module fpe_baud #(
   parameter int CW = 24
) (
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic          enable,
   input  wire logic          rx_level,
   output logic      [CW-1:0] bit_cycles,
   output logic               locked,
   output logic               bit_tick
);
   // Detector state
   typedef struct packed {
      fpe_pkg::fpe_baud_e st;
      logic [CW-1:0]      cnt;
      logic [CW-1:0]      div;
      logic [CW-1:0]      tick_cnt;
      logic               tick;
   } fpe_baud_s;

   fpe_baud_s b_reg;  // Registered state
   fpe_baud_s b_next; // Next state
   logic [CW+6:0] prod; // Low time scaled toward one bit

   // Low time of a zero byte spans nine bits; scale by 57/512
   assign prod = (CW+7)'(b_reg.cnt) * (CW+7)'(fpe_pkg::RECIP_MUL);

   // Measure the first low run, then free-run a tick at that rate
   always_comb begin
      b_next      = b_reg;
      b_next.tick = 1'b0;
      unique case (b_reg.st)
         fpe_pkg::FPE_B_WAIT_HIGH: begin
            // Line must idle high first
            if (rx_level) begin
               b_next.st = fpe_pkg::FPE_B_WAIT_LOW;
            end
         end
         fpe_pkg::FPE_B_WAIT_LOW: begin
            // Start bit opens the measurement
            b_next.cnt = '0;
            if (!rx_level) begin
               b_next.st = fpe_pkg::FPE_B_MEASURE;
            end
         end
         fpe_pkg::FPE_B_MEASURE: begin
            if (rx_level) begin
               b_next.div = CW'(prod >> fpe_pkg::RECIP_SHIFT);
               b_next.st  = fpe_pkg::FPE_B_LOCKED;
            end else if (b_reg.cnt != '1) begin
               b_next.cnt = b_reg.cnt + CW'(1);
            end
         end
         fpe_pkg::FPE_B_LOCKED: begin
            // Serial channel bit enable at the measured rate
            // Tick on the last count so the period is exactly div cycles
            if ((b_reg.tick_cnt + CW'(1)) >= b_reg.div) begin
               b_next.tick_cnt = '0;
               b_next.tick     = 1'b1;
            end else begin
               b_next.tick_cnt = b_reg.tick_cnt + CW'(1);
            end
         end
      endcase
      // Leaving boot mode drops the measurement
      if (!enable) begin
         b_next.st       = fpe_pkg::FPE_B_WAIT_HIGH;
         b_next.tick_cnt = '0;
         b_next.tick     = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         b_reg <= '0;
      end else begin
         b_reg <= b_next;
      end
   end

   assign bit_cycles = b_reg.div;
   assign locked     = (b_reg.st == fpe_pkg::FPE_B_LOCKED);
   assign bit_tick   = b_reg.tick;
endmodule : fpe_baud

/* design/fpe_top.sv */
// Flash mode control, block select registers, flash array and boot bit rate detector
//
// Contract
// - Flash array mapped at 0000-7FFF, 32 kbytes.
// - Mode pins: 00 illegal, 01 external, 1x flash.
// - 16-bit path, byte and word reads two states.
// - Control registers reachable only with 12 V.
// - No 12 V: mode 2 external, mode 3 FF.
// - Mode 1 ignores writes, reads FF.
// - Mode control cleared on reset, standby, no supply.
// - With supply, reset leaves mode control at 80.
// - Bit 7 is read-only supply flag.
// - Bits 6-4 read zero, writes ignored.
// - Bit 3 enters and leaves erase-verify.
// - Bit 2 enters and leaves program-verify.
// - Bit 1 enters and leaves erase.
// - Bit 0 enters and leaves program.
// - Large select set to F0 on reset, standby, no supply.
// - Large select bits 7-4 read one, fixed.
// - Large bits 3-0 select four large blocks.
// - Four large and eight small erase blocks.
// - Boot mode matches host bit rate up to 9600.
// - Small select bits pick eight small blocks.
`timescale 1ns/1ns
module fpe_top #(
   parameter int BAUD_CW = 24
) (
   input  wire logic               clock,
   input  wire logic               nrst,
   input  wire logic [15:0]        avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic               programming_supply_pin,
   input  wire logic               mode_pin_high,
   input  wire logic               mode_pin_low,
   input  wire logic               boot_mode_pin,
   input  wire logic               boot_serial_in,
   input  wire logic               standby,
   output logic                    ext_access,
   output logic                    mode_illegal,
   output logic                    program_mode,
   output logic                    erase_mode,
   output logic                    program_verify_mode,
   output logic                    erase_verify_mode,
   output logic [BAUD_CW-1:0]      baud_bit_cycles,
   output logic                    baud_locked,
   output logic                    baud_tick
);
   localparam int WORDS = fpe_pkg::FLASH_BYTES / 2; // 16-bit words in the array
   localparam int WA    = $clog2(WORDS);            // Word address width

   // Whole control state of the block
   typedef struct packed {
      fpe_pkg::fpe_state_e st;
      logic [3:0]          mode_bits;    // Erase-verify, program-verify, erase, program
      logic [3:0]          large_block_bits;
      logic [7:0]          small_block_bits;
      logic [7:0]          wait_ctrl;
      logic [31:0]         rdata;
      logic [WA-1:0]       sweep;
   } fpe_top_s;

   fpe_top_s s_reg;  // Registered state
   fpe_top_s s_next; // Next state

   logic [15:0]   mem [WORDS];  // Flash array, one 16-bit word per entry
   logic          mem_we;       // Array write strobe
   logic [WA-1:0] mem_wa;       // Array write word address
   logic [15:0]   mem_wd;       // Array write data
   logic [15:0]   mem_rword;    // Word under the bus address
   logic [1:0]    mode;         // Filtered mode pins
   logic          vpp;          // Filtered 12 V present flag
   logic          boot;         // Filtered boot mode pin
   logic          rx;           // Filtered serial input
   logic          flash_on;     // Array mapped on chip
   logic          in_flash;     // Address hits the array window
   logic          is_ctl;       // Address hits a supply-gated register
   logic          ctl_ok;       // Supply-gated registers usable
   logic          regs_clr;     // Force registers to their idle values
   logic [7:0]    rd8;          // Register byte under the bus address
   logic [15:0]   blk_addr;     // Address whose block is checked
   logic [15:0]   wa_byte;      // Program write byte address
   logic          sel_hit;      // Program write block is selected
   logic [WA-1:0] word_idx;     // Word index of the bus address

   // Pin synchronisers for mode, supply and boot pins
   fpe_sync #(
      .WIDTH (4),
      .INIT  (1'b0)
   ) u_pin_sync (
      .clock     (clock),
      .nrst      (nrst),
      .pin_in    ({mode_pin_high, mode_pin_low, programming_supply_pin, boot_mode_pin}),
      .level_out ({mode, vpp, boot})
   );

   // Serial input idles high, so its synchroniser starts high
   fpe_sync #(
      .WIDTH (1),
      .INIT  (1'b1)
   ) u_rx_sync (
      .clock     (clock),
      .nrst      (nrst),
      .pin_in    (boot_serial_in),
      .level_out (rx)
   );

   // Host bit rate alignment, active only in boot mode
   fpe_baud #(
      .CW (BAUD_CW)
   ) u_baud (
      .clock      (clock),
      .nrst       (nrst),
      .enable     (boot && vpp && flash_on),
      .rx_level   (rx),
      .bit_cycles (baud_bit_cycles),
      .locked     (baud_locked),
      .bit_tick   (baud_tick)
   );

   // Block select lookup over the four large and eight small blocks
   function automatic logic block_sel(
      input logic [15:0] a,
      input logic [3:0]  lb,
      input logic [7:0]  sb
   );
      logic r;
      r = 1'b0;
      if (a < fpe_pkg::SMALL_AREA_END) begin
         if (a < fpe_pkg::SB4_START) begin
            r = sb[a[8:7]];
         end else if (a < fpe_pkg::SB5_START) begin
            r = sb[4];
         end else if (a < fpe_pkg::SB6_START) begin
            r = sb[5];
         end else if (a < fpe_pkg::SB7_START) begin
            r = sb[6];
         end else begin
            r = sb[7];
         end
      end else if (a < fpe_pkg::LB1_START) begin
         r = lb[0];
      end else if (a < fpe_pkg::LB2_START) begin
         r = lb[1];
      end else if (a < fpe_pkg::LB3_START) begin
         r = lb[2];
      end else begin
         r = lb[3];
      end
      return r;
   endfunction : block_sel

   // Address decode and register visibility
   always_comb begin
      flash_on = (mode == fpe_pkg::MODE_ONCHIP_A) || (mode == fpe_pkg::MODE_ONCHIP_B);
      mode_illegal = (mode == fpe_pkg::MODE_ILLEGAL);
      in_flash = flash_on && (avs_address <= fpe_pkg::FLASH_HI);
      is_ctl   = (avs_address == fpe_pkg::FLASH_MODE_CTRL_IDX) ||
                 (avs_address == fpe_pkg::LARGE_BLOCK_SEL_IDX) ||
                 (avs_address == fpe_pkg::SMALL_BLOCK_SEL_IDX);
      ctl_ok   = flash_on && vpp;
      // Mode 2 without supply hands these addresses to the outside
      ext_access = (avs_read || avs_write) &&
                   ((is_ctl && !vpp && (mode == fpe_pkg::MODE_ONCHIP_A)) ||
                    ((mode == fpe_pkg::MODE_EXTERNAL) && (avs_address <= fpe_pkg::FLASH_HI)));
      // Standby, lost supply or disabled flash hold the idle values
      regs_clr = standby || !vpp || !flash_on;
      word_idx = avs_address[WA:1];
   end

   // Register read byte
   always_comb begin
      rd8 = 8'h00;
      if (!flash_on) begin
         rd8 = fpe_pkg::OFF_READ;
      end else if (!vpp) begin
         rd8 = (mode == fpe_pkg::MODE_ONCHIP_B) ? fpe_pkg::OFF_READ : 8'h00;
      end else if (avs_address == fpe_pkg::FLASH_MODE_CTRL_IDX) begin
         // Supply flag live, bits 6-4 zero
         rd8 = {vpp, 3'b000, s_reg.mode_bits};
      end else if (avs_address == fpe_pkg::LARGE_BLOCK_SEL_IDX) begin
         rd8 = {fpe_pkg::LARGE_FIXED_ONES, s_reg.large_block_bits};
      end else begin
         rd8 = s_reg.small_block_bits;
      end
   end

   // Array read word
   assign mem_rword = mem[word_idx];

   // Bus sequencing, register writes and erase sweep
   always_comb begin
      s_next   = s_reg;
      mem_we   = 1'b0;
      mem_wa   = word_idx;
      mem_wd   = mem_rword;
      blk_addr = {avs_address[15:1], 1'b0};
      wa_byte  = avs_address;
      sel_hit  = 1'b0;
      unique case (s_reg.st)
         fpe_pkg::FPE_IDLE: begin
            // First state of every access; capture read data
            if (avs_read || avs_write) begin
               s_next.st    = fpe_pkg::FPE_ACK;
               s_next.rdata = 32'h0000_0000;
               if (in_flash) begin
                  // Odd byte lands in the low lane, even gives the word
                  s_next.rdata = avs_address[0] ? {24'h00_0000, mem_rword[15:8]} : {16'h0000, mem_rword};
               end else if (is_ctl) begin
                  s_next.rdata = {24'h00_0000, rd8};
               end else if (avs_address == fpe_pkg::WAIT_STATE_CTRL_IDX) begin
                  s_next.rdata = {24'h00_0000, s_reg.wait_ctrl};
               end
            end
         end
         fpe_pkg::FPE_ACK: begin
            // Second state: answer, and apply any write
            s_next.st = fpe_pkg::FPE_IDLE;
            if (avs_write && avs_byteenable[0] && is_ctl && ctl_ok) begin
               unique case (avs_address)
                  fpe_pkg::FLASH_MODE_CTRL_IDX: begin
                     // Only the four mode bits take writes
                     s_next.mode_bits = avs_writedata[3:0];
                     if (avs_writedata[fpe_pkg::E_BIT] && !s_reg.mode_bits[fpe_pkg::E_BIT]) begin
                        s_next.st    = fpe_pkg::FPE_ERASE;
                        s_next.sweep = '0;
                     end
                  end
                  fpe_pkg::LARGE_BLOCK_SEL_IDX: begin
                     s_next.large_block_bits = avs_writedata[3:0];
                  end
                  default: begin
                     s_next.small_block_bits = avs_writedata[7:0];
                  end
               endcase
            end else if (avs_write && avs_byteenable[0] && (avs_address == fpe_pkg::WAIT_STATE_CTRL_IDX)) begin
               s_next.wait_ctrl = avs_writedata[7:0];
            end else if (avs_write && in_flash && program_mode) begin
               // Programming only clears bits in a selected block
               sel_hit = block_sel(wa_byte, s_reg.large_block_bits, s_reg.small_block_bits);
               mem_we  = sel_hit;
               if (avs_address[0]) begin
                  mem_wd[15:8] = mem_rword[15:8] & (avs_byteenable[0] ? avs_writedata[7:0] : 8'hFF);
               end else begin
                  mem_wd[7:0]  = mem_rword[7:0] & (avs_byteenable[0] ? avs_writedata[7:0] : 8'hFF);
                  mem_wd[15:8] = mem_rword[15:8] & (avs_byteenable[1] ? avs_writedata[15:8] : 8'hFF);
               end
            end
         end
         fpe_pkg::FPE_ERASE: begin
            // Walk the array, erasing words of selected blocks
            mem_wa   = s_reg.sweep;
            blk_addr = {1'b0, s_reg.sweep, 1'b0};
            mem_wd   = 16'hFFFF;
            mem_we   = erase_mode &&
                       block_sel(blk_addr, s_reg.large_block_bits, s_reg.small_block_bits);
            s_next.sweep = s_reg.sweep + WA'(1);
            if ((s_reg.sweep == WA'(WORDS - 1)) || !erase_mode) begin
               s_next.st = fpe_pkg::FPE_IDLE;
            end
         end
         default: begin
            // Unused code returns to idle
            s_next.st = fpe_pkg::FPE_IDLE;
         end
      endcase
      // Idle values while supply, mode or standby forbid use
      if (regs_clr) begin
         s_next.mode_bits        = fpe_pkg::MODE_CTRL_RST[3:0];
         s_next.large_block_bits = fpe_pkg::LARGE_SEL_RST[3:0];
         s_next.small_block_bits = fpe_pkg::SMALL_SEL_RST;
      end
   end

   // State register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg                  <= '0;
         s_reg.st               <= fpe_pkg::FPE_IDLE;
         s_reg.mode_bits        <= fpe_pkg::MODE_CTRL_RST[3:0];
         s_reg.large_block_bits <= fpe_pkg::LARGE_SEL_RST[3:0];
         s_reg.small_block_bits <= fpe_pkg::SMALL_SEL_RST;
         s_reg.wait_ctrl        <= fpe_pkg::WAIT_CTRL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // Array write port
   always_ff @(posedge clock) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // Bus answers and flash operating mode outputs
   assign avs_waitrequest     = (s_reg.st != fpe_pkg::FPE_ACK);
   assign avs_readdata        = s_reg.rdata;
   assign program_mode        = ctl_ok && s_reg.mode_bits[fpe_pkg::P_BIT];
   assign erase_mode          = ctl_ok && s_reg.mode_bits[fpe_pkg::E_BIT];
   assign program_verify_mode = ctl_ok && s_reg.mode_bits[fpe_pkg::PV_BIT];
   assign erase_verify_mode   = ctl_ok && s_reg.mode_bits[fpe_pkg::EV_BIT];
endmodule : fpe_top

/* bench/fpe_monitor.sv */
// Port-level assertions for the flash control block
`timescale 1ns/1ns
module fpe_monitor (
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic [15:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        programming_supply_pin,
   input wire logic        mode_pin_high,
   input wire logic        mode_pin_low,
   input wire logic        standby,
   input wire logic        ext_access,
   input wire logic        mode_illegal,
   input wire logic        program_mode,
   input wire logic        erase_mode,
   input wire logic        program_verify_mode,
   input wire logic        erase_verify_mode
);
   // One clock domain, reset disables all
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack held");
   AST_TWO_STATE: assert property ($rose(avs_read) && !erase_mode |=> !avs_waitrequest)
      else $error("slow read");
   AST_NO_SUPPLY: assert property (!programming_supply_pin [*5] |-> !program_mode && !erase_mode
      && !program_verify_mode && !erase_verify_mode) else $error("mode without supply");
   AST_STANDBY: assert property (standby |=> !program_mode && !erase_mode) else $error("standby kept mode");
   AST_ILLEGAL: assert property ((!mode_pin_high && !mode_pin_low) [*5] |-> mode_illegal)
      else $error("illegal not flagged");
   AST_EXT: assert property ((!mode_pin_high && mode_pin_low) [*5] ##0 avs_read && avs_address <= 16'h7FFF
      |-> ext_access) else $error("flash not external");
   AST_MODE1_FF: assert property ((!mode_pin_high && mode_pin_low) [*6] ##0 avs_read && !avs_waitrequest
      && avs_address == 16'hFF83 |-> avs_readdata[7:0] == 8'hFF) else $error("mode 1 read");
   AST_OFF_FF: assert property ((!programming_supply_pin && mode_pin_high && mode_pin_low) [*6] ##0 avs_read
      && !avs_waitrequest && avs_address == 16'hFF80 |-> avs_readdata[7:0] == 8'hFF) else $error("off read");
   AST_MODE_BITS: assert property ((programming_supply_pin && mode_pin_high && !standby) [*5] ##0 avs_write
      && !avs_waitrequest && avs_address == 16'hFF80 |=> {erase_verify_mode, program_verify_mode,
      erase_mode, program_mode} == $past(avs_writedata[3:0])) else $error("mode bits");
endmodule : fpe_monitor

bind fpe_top fpe_monitor u_monitor (.clock, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_readdata, .avs_waitrequest, .programming_supply_pin, .mode_pin_high, .mode_pin_low, .standby,
   .ext_access, .mode_illegal, .program_mode, .erase_mode, .program_verify_mode, .erase_verify_mode);

/* bench/fpe_cpu.sv */
// CPU-side bus master model, one Avalon transfer per call
`timescale 1ns/1ns
module fpe_cpu (
   input  wire logic        clock,
   output logic      [15:0] avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   // Idle bus at time zero; both bytes always enabled
   initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
   assign avs_byteenable = 4'h3;
   // Program and erase bits are cleared by software in time, no watchdog
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge clock);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= {16'h0000, d};
      // Hold until the answering edge; only the bench watchdog ends a hang
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[15:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : xfer
endmodule : fpe_cpu

/* bench/tb_fpe_top.sv */
// Self-checking bench for the flash control block
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_fpe_top;
   logic clock = 1'b0, nrst = 1'b0, standby = 1'b0;  // Clock, reset, standby entry
   logic programming_supply_pin = 1'b1, mode_pin_high = 1'b1, mode_pin_low = 1'b1;  // Pins, mode 3
   logic [15:0] avs_address;  // Bus from CPU model
   logic avs_read, avs_write, avs_waitrequest, ext_access, mode_illegal;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic program_mode, erase_mode, program_verify_mode, erase_verify_mode;
   logic boot_mode_pin = 1'b0, boot_serial_in = 1'b1;  // Boot pin and host serial line, idle high
   logic baud_locked, baud_tick;                       // Bit rate detector outputs
   logic [23:0] baud_bit_cycles;                       // Measured cycles per bit
   int ticks = 0;                                      // Bit ticks seen in a window
   int num_errors = 0, total_checks = 0;  // Counters
   // 250 MHz clock
   always #2 clock = ~clock;
   fpe_cpu cpu (.clock, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest);
   fpe_top DUT (.clock, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .programming_supply_pin, .mode_pin_high, .mode_pin_low,
      .boot_mode_pin, .boot_serial_in, .standby, .ext_access, .mode_illegal, .program_mode,
      .erase_mode, .program_verify_mode, .erase_verify_mode, .baud_bit_cycles, .baud_locked, .baud_tick);
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] q;
      cpu.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] q;
      cpu.xfer(1'b0, a, 16'h0000, q);
      `CHK(q, e)
   endtask : rd
   // Pins change, then wait out the synchronisers
   task automatic pins(input logic v, input logic h, input logic l);
      programming_supply_pin <= v;
      mode_pin_high <= h;
      mode_pin_low <= l;
      repeat (6) @(posedge clock);
   endtask : pins
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   // Watchdog over two erase sweeps and register traffic
   initial begin
      #240000;
      num_errors++;
      give_verdict();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      repeat (8) @(posedge clock);
      rd(16'hFF80, 16'h0080);
      rd(16'hFF82, 16'h00F0);
      rd(16'hFF83, 16'h0000);
      rd(16'hFFC2, 16'h0008);
      rd(16'hFF81, 16'h0000);
      $display("reset values done");
      for (int i = 0; i < 4; i++) begin
         wr(16'hFF80, 16'h0070 | (16'h1 << i));
         rd(16'hFF80, 16'h0080 | (16'h1 << i));
      end
      wr(16'hFF82, 16'h0005);
      rd(16'hFF82, 16'h00F5);
      wr(16'hFF83, 16'h00A5);
      rd(16'hFF83, 16'h00A5);
      standby <= 1'b1;
      repeat (2) @(posedge clock);
      standby <= 1'b0;
      rd(16'hFF80, 16'h0080);
      rd(16'hFF82, 16'h00F0);
      rd(16'hFF83, 16'h0000);
      $display("mode and select registers done");
      wr(16'hFF83, 16'h0001);
      wr(16'hFF80, 16'h0002);
      rd(16'h0000, 16'hFFFF);
      wr(16'hFF80, 16'h0001);
      wr(16'h0000, 16'h1234);
      rd(16'h0000, 16'h1234);
      rd(16'h0001, 16'h0012);
      wr(16'hFF80, 16'h0000);
      $display("flash access done");
      pins(1'b0, 1'b1, 1'b1);
      wr(16'hFF80, 16'h0001);
      rd(16'hFF80, 16'h00FF);
      pins(1'b0, 1'b1, 1'b0);
      rd(16'hFF80, 16'h0000);
      pins(1'b1, 1'b1, 1'b1);
      rd(16'hFF80, 16'h0080);
      rd(16'hFF83, 16'h0000);
      // Host sends a zero byte at 64 cycles per bit: nine low bits
      boot_mode_pin <= 1'b1;
      repeat (8) @(posedge clock);
      boot_serial_in <= 1'b0;
      repeat (9 * 64) @(posedge clock);
      boot_serial_in <= 1'b1;
      repeat (8) @(posedge clock);
      `CHK(baud_locked, 1'b1)
      `CHK(baud_bit_cycles, 24'h000040)
      // Ten bit periods must give ten ticks
      repeat (640) @(posedge clock) ticks = ticks + int'(baud_tick);
      `CHK(ticks, 10)
      $display("boot bit rate done");
      pins(1'b1, 1'b0, 1'b1);
      wr(16'hFF83, 16'h0055);
      rd(16'hFF83, 16'h00FF);
      wr(16'h0000, 16'h0000);
      rd(16'h0000, 16'h0000);
      pins(1'b1, 1'b0, 1'b0);
      `CHK(mode_illegal, 1'b1)
      $display("supply and mode pins done");
      give_verdict();
   end
endmodule : tb_fpe_top
